// ---- cdd_ctrl_status.sv ----
// Operation
// - Reset clears the second control register.
// - Interpolation enabled inserts a missing sync to keep block timing.
// - Detection enabled realigns block timing to syncs found in the stream.
// - Descramble bit set descrambles data; clear passes raw data.
// - Rewrite bit lets corrected bytes be written back; clear means CRC only.
// - Mode request selects Mode 1 when 0, Mode 2 when 1.
// - Form request selects Form 1 when 0, Form 2 when 1.
// - Mode check with mismatching mode byte disables correction and clears the CRC pass bit.
// - Select bit shows header bytes when 0, sub-header bytes when 1.
// - Reset clears block status and header error flags.
// - CRC pass bit is 1 on CRC pass, 0 on failure.
// - Illegal sync flag when sync found off position and timing realigned.
// - Inserted sync flag when count reaches 1175 with no sync.
// - No interpolation and missing sync extends block, sets long flag.
// - Short flag on early sync; ignored while detection disabled.
// - Erasure flag when any block byte carried an erasure mark.
// - Uncorrectable flag when a byte stays in error after correction.
// - Header error bits: minutes, seconds, frames, mode, sub-header 0..3.
// - Mode/form bits encode 00 Mode1, 10 Mode2 Form1, X1 Form2/impossible.
// - Mode bit copies request; form from request or header when automatic.
// - Form bit forced to 1 whenever correction is impossible.
// - Bits 1..0 preview next form: 00, 01, or 1X on form byte error.
// - Bits 7..4 preview next mode byte, ORed with that byte's erasure mark.
// - Preview 1XXX means mode above 7 or mode byte error.
// - Sub-header view uses bytes 20..23, first copy for flagged bytes.
// - Automatic form bit takes form from sub-header in Mode 2.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cdd_ctrl_status
  import cdd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic din_toggle,
  input wire logic [15:0] din_word,
  input wire logic [1:0] erasure_input,
  input wire logic corr_done,
  input wire logic corr_crc_ok,
  input wire logic corr_uncorrectable,
  output logic out_valid,
  output logic [15:0] out_word,
  output logic block_end,
  output logic corr_enable,
  output logic corr_mode,
  output logic corr_form,
  output logic rewrite_enable
);

  // Register index decode, shared by the read and write paths; 15 is unmapped
  function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    reg_sel = 4'hF;
    if (b[1:0] == 2'h0) begin
      if (b == OFS_CTRL_B) reg_sel = 4'h0;
      else if (b == OFS_BSTAT) reg_sel = 4'h1;
      else if (b == OFS_HERR) reg_sel = 4'h2;
      else if (b == OFS_MFSTAT) reg_sel = 4'h3;
      else if (b == OFS_CTRL_A) reg_sel = 4'h4;
      else if (b >= OFS_HEADER_BYTE_REG0 && b <= OFS_HEADER_BYTE_REG3) reg_sel = 4'(4'h5 + b[5:2] - OFS_HEADER_BYTE_REG0[5:2]);
    end
  endfunction

  // Sixteen scrambler steps: first byte takes the first eight key bits, LSB first
  function automatic logic [30:0] scr_word(input logic [14:0] s);
    logic [14:0] st;
    logic [15:0] key;
    st = s;
    key = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      if (k < 8) key[8 + k] = st[0];
      else key[k - 8] = st[0];
      st = {st[0] ^ st[1], st[14:1]};
    end
    scr_word = {st, key};
  endfunction

  // Pin synchronisers; data must stay stable until the toggle has crossed
  logic [2:0] tog_sync;
  logic [15:0] word_s1, word_s2;
  logic [1:0] era_s1, era_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tog_sync <= 3'h0;
      word_s1 <= 16'h0000;
      word_s2 <= 16'h0000;
      era_s1 <= 2'h0;
      era_s2 <= 2'h0;
    end else begin
      tog_sync <= {tog_sync[1:0], din_toggle};
      word_s1 <= din_word;
      word_s2 <= word_s1;
      era_s1 <= erasure_input;
      era_s2 <= era_s1;
    end
  end
  wire w_stb = tog_sync[2] ^ tog_sync[1];

  // Software-written control
  logic [7:0] decoder_control_b, decoder_control_a;
  wire interp_en = decoder_control_b[CB_INTERP];
  wire detect_en = decoder_control_b[CB_DETECT];
  wire mode_request = decoder_control_b[CB_MODE];
  wire form_request = decoder_control_b[CB_FORM];
  wire mode_check_enable = decoder_control_b[CB_MCHK];
  wire auto_form_enable = decoder_control_a[CA_AUTO];

  // Block timing and header capture state
  cdd_bt_t bt, next_bt;
  logic [10:0] wc, next_wc;
  logic [14:0] scr, next_scr;
  logic [15:0] hist [0:4];
  logic [15:0] next_hist [0:4];
  logic [7:0] hb [0:11];
  logic [7:0] next_hb [0:11];
  logic [11:0] he, next_he;
  logic f_ils, f_ins, f_long, f_short, f_era;
  logic next_f_ils, next_f_ins, next_f_long, next_f_short, next_f_era;
  logic [3:0] pv_mode, next_pv_mode;
  logic [1:0] pv_form, next_pv_form;
  logic next_out_valid, next_block_end;
  logic [15:0] next_out_word;
  logic [4:0] fin_flags;

  // Word strobe: sync search, counting, descrambling and header capture
  always_comb begin
    logic match, at_pos, blk_done;
    logic [30:0] sw;
    logic [15:0] dw;
    match = (hist[4] == SYNC_FIRST) && (word_s2 == SYNC_LAST);
    for (int i = 0; i < 4; i++) match = match && (hist[i] == SYNC_MID);
    at_pos = (wc == WC_SYNC_POS);
    sw = scr_word(scr);
    dw = decoder_control_b[CB_DESCR] ? (word_s2 ^ sw[15:0]) : word_s2;
    blk_done = 1'b0;
    next_bt = bt;
    next_wc = wc;
    next_scr = scr;
    next_hist = hist;
    next_hb = hb;
    next_he = he;
    next_f_ils = f_ils;
    next_f_ins = f_ins;
    next_f_long = f_long;
    next_f_short = f_short;
    next_f_era = f_era;
    fin_flags = {f_ils, f_ins, f_long, f_short, f_era};
    next_pv_mode = pv_mode;
    next_pv_form = pv_form;
    next_out_valid = 1'b0;
    next_out_word = out_word;
    if (w_stb) begin
      next_hist[0] = word_s2;
      for (int i = 1; i < 5; i++) next_hist[i] = hist[i - 1];
      if (|era_s2) next_f_era = 1'b1;
      if (wc < WC_DATA_END) begin
        next_scr = sw[30:16];
        next_out_valid = 1'b1;
        next_out_word = dw;
      end
      if (wc < 11'(HDR_WORDS)) begin
        next_hb[2 * wc[2:0]] = dw[15:8];
        next_hb[2 * wc[2:0] + 1] = dw[7:0];
        next_he[2 * wc[2:0]] = era_s2[1];
        next_he[2 * wc[2:0] + 1] = era_s2[0];
      end
      // Preview of the block now arriving, taken as its bytes pass
      if (wc == 11'h001) begin
        next_pv_mode[3] = (|dw[7:3]) | era_s2[0];
        next_pv_mode[2:0] = dw[2:0] | {3{era_s2[0]}};
      end
      if (wc == 11'h003) next_pv_form = {era_s2[1], dw[8 + SUBMODE_FORM_BIT]};
      if (match && at_pos) begin
        blk_done = 1'b1;
      end else if (match && detect_en) begin
        blk_done = 1'b1;
        next_f_ils = 1'b1;
        if (wc < WC_SYNC_POS) next_f_short = 1'b1;
      end else if (at_pos && bt == BT_RUN) begin
        if (interp_en) begin
          blk_done = 1'b1;
          next_f_ins = 1'b1;
        end else begin
          next_bt = BT_LONG;
          next_f_long = 1'b1;
          next_f_ins = 1'b1;
        end
      end else if (wc == WC_MAX) begin
        blk_done = 1'b1; // Bounds a block that never finds a sync
      end
      // Snapshot before the clear, so flags raised by the closing word still count
      fin_flags = {next_f_ils, next_f_ins, next_f_long, next_f_short, next_f_era};
      if (blk_done) begin
        next_bt = BT_RUN;
        next_wc = 11'h000;
        next_scr = SCR_SEED;
        next_f_ils = 1'b0;
        next_f_ins = 1'b0;
        next_f_long = 1'b0;
        next_f_short = 1'b0;
        next_f_era = 1'b0;
      end else begin
        next_wc = 11'(wc + 11'h001);
      end
    end
    next_block_end = blk_done;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bt <= BT_RUN;
      wc <= 11'h000;
      scr <= SCR_SEED;
      for (int i = 0; i < 5; i++) hist[i] <= 16'h0000;
      for (int i = 0; i < 12; i++) hb[i] <= 8'h00;
      he <= 12'h000;
      {f_ils, f_ins, f_long, f_short, f_era} <= 5'h00;
      pv_mode <= 4'h0;
      pv_form <= 2'h0;
      out_valid <= 1'b0;
      out_word <= 16'h0000;
      block_end <= 1'b0;
    end else begin
      bt <= next_bt;
      wc <= next_wc;
      scr <= next_scr;
      hist <= next_hist;
      hb <= next_hb;
      he <= next_he;
      {f_ils, f_ins, f_long, f_short, f_era} <=
        {next_f_ils, next_f_ins, next_f_long, next_f_short, next_f_era};
      pv_mode <= next_pv_mode;
      pv_form <= next_pv_form;
      out_valid <= next_out_valid;
      out_word <= next_out_word;
      block_end <= next_block_end;
    end
  end

  // Pending results of the finished block, then published on corr_done
  logic [4:0] pend_flags, next_pend_flags;
  logic [7:0] pend_herr, next_pend_herr;
  logic [7:0] pend_hdr [0:7];
  logic [7:0] next_pend_hdr [0:7];
  logic pend_form, next_pend_form, pend_chk_ok, next_pend_chk_ok;
  logic next_corr_enable, next_corr_mode, next_corr_form, next_rewrite_enable;
  logic [7:0] block_status_a, header_error_flags, mode_form_status;
  logic [7:0] next_bstat, next_herr, next_mfstat;
  logic [7:0] head_reg [0:7];
  logic [7:0] next_head_reg [0:7];

  always_comb begin
    logic [7:0] submode;
    logic form_raw, mchk_bad, impossible, sub_err;
    submode = he[10] ? hb[6] : hb[10];
    form_raw = auto_form_enable ? submode[SUBMODE_FORM_BIT] : form_request;
    mchk_bad = mode_check_enable &&
      ((hb[3] != (mode_request ? MODE2_BYTE : MODE1_BYTE)) || he[3]);
    sub_err = mode_request && he[10] && he[6];
    impossible = fin_flags[4] || fin_flags[2] || (mode_request && form_raw) || sub_err ||
      mchk_bad;
    next_pend_flags = pend_flags;
    next_pend_herr = pend_herr;
    next_pend_hdr = pend_hdr;
    next_pend_form = pend_form;
    next_pend_chk_ok = pend_chk_ok;
    next_corr_enable = corr_enable;
    next_corr_mode = corr_mode;
    next_corr_form = corr_form;
    next_rewrite_enable = rewrite_enable;
    if (next_block_end) begin
      next_pend_flags = {fin_flags[4:2], fin_flags[1] & detect_en, fin_flags[0]};
      next_pend_herr = {he[0], he[1], he[2], he[3], he[8], he[9], he[10], he[11]};
      for (int i = 0; i < 4; i++) begin
        next_pend_hdr[i] = hb[i];
        next_pend_hdr[4 + i] = he[8 + i] ? hb[4 + i] : hb[8 + i];
      end
      next_pend_form = (mode_request & form_raw) | impossible;
      next_pend_chk_ok = !mchk_bad;
      next_corr_enable = !mchk_bad;
      next_corr_mode = mode_request;
      next_corr_form = form_raw;
      next_rewrite_enable = decoder_control_b[CB_REWRITE];
    end
    next_bstat = block_status_a;
    next_herr = header_error_flags;
    next_head_reg = head_reg;
    next_mfstat = {pv_mode, mode_form_status[3:2], pv_form};
    if (corr_done) begin
      next_bstat = {corr_crc_ok & pend_chk_ok, pend_flags[4:2], 1'b0,
        pend_flags[1:0], corr_uncorrectable};
      next_herr = pend_herr;
      next_head_reg = pend_hdr;
      next_mfstat[3:2] = {decoder_control_b[CB_MODE], pend_form};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_flags <= 5'h00;
      pend_herr <= 8'h00;
      for (int i = 0; i < 8; i++) pend_hdr[i] <= 8'h00;
      for (int i = 0; i < 8; i++) head_reg[i] <= 8'h00;
      pend_form <= 1'b0;
      pend_chk_ok <= 1'b0;
      corr_enable <= 1'b0;
      corr_mode <= 1'b0;
      corr_form <= 1'b0;
      rewrite_enable <= 1'b0;
      block_status_a <= STAT_RST;
      header_error_flags <= STAT_RST;
      mode_form_status <= STAT_RST;
    end else begin
      pend_flags <= next_pend_flags;
      pend_herr <= next_pend_herr;
      pend_hdr <= next_pend_hdr;
      head_reg <= next_head_reg;
      pend_form <= next_pend_form;
      pend_chk_ok <= next_pend_chk_ok;
      corr_enable <= next_corr_enable;
      corr_mode <= next_corr_mode;
      corr_form <= next_corr_form;
      rewrite_enable <= next_rewrite_enable;
      block_status_a <= next_bstat;
      header_error_flags <= next_herr;
      mode_form_status <= next_mfstat;
    end
  end

  // AXI4-Lite slave: address and data taken in either order, one of each held
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane;
  logic [7:0] next_ctrl_b, next_ctrl_a;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  always_comb begin
    logic [3:0] ws, rs;
    logic [7:0] rv;
    ws = 4'hF;
    rs = 4'hF;
    rv = 8'h00;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_ctrl_b = decoder_control_b;
    next_ctrl_a = decoder_control_a;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    // Register writes; only lane 0 carries bits, read-only targets ignore data
    ws = reg_sel(aw_addr);
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (ws == 4'hF) ? RESP_SLVERR : RESP_OKAY;
      if (w_lane && ws == 4'h0) next_ctrl_b = w_byte;
      if (w_lane && ws == 4'h4) next_ctrl_a = w_byte;
    end
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    rs = reg_sel(s_axi_araddr);
    case (rs)
      4'h0: rv = decoder_control_b;
      4'h1: rv = block_status_a;
      4'h2: rv = header_error_flags;
      4'h3: rv = mode_form_status;
      4'h4: rv = decoder_control_a;
      4'h5, 4'h6, 4'h7, 4'h8: rv = head_reg[{decoder_control_b[CB_SHSEL], 2'(rs - 4'h5)}];
      default: rv = 8'h00;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, rv};
      next_rresp = (rs == 4'hF) ? RESP_SLVERR : RESP_OKAY;
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      decoder_control_b <= CTRL_B_RST;
      decoder_control_a <= CTRL_A_RST;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      decoder_control_b <= next_ctrl_b;
      decoder_control_a <= next_ctrl_a;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ---- cdd_dsp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdd_dsp_model
  import cdd_pkg::*;
(
  input wire logic aclk,
  output logic din_toggle,
  output logic [15:0] din_word,
  output logic [1:0] erasure_input
);
  initial begin
    din_toggle = 1'h0;
    din_word = 16'h0;
    erasure_input = 2'h0;
  end
  // Data settles a cycle before the toggle and holds five after it
  task automatic send(input logic [15:0] w, input logic [1:0] e);
    @(posedge aclk);
    din_word <= w;
    erasure_input <= e;
    @(posedge aclk);
    din_toggle <= ~din_toggle;
    repeat (5) @(posedge aclk);
    // Hold time over: inverse so a late capture shows as garbage
    din_word <= ~w;
    erasure_input <= ~e;
  endtask
  task automatic sync_pat();
    send(SYNC_FIRST, 2'h0);
    repeat (4) send(SYNC_MID, 2'h0);
    send(SYNC_LAST, 2'h0);
  endtask
endmodule
`default_nettype wire

// ---- cdd_pkg.sv ----
`default_nettype none
package cdd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_B = 8'h00;
  localparam logic [7:0] OFS_BSTAT = 8'h04;
  localparam logic [7:0] OFS_HERR = 8'h08;
  localparam logic [7:0] OFS_MFSTAT = 8'h0C;
  localparam logic [7:0] OFS_CTRL_A = 8'h10;
  localparam logic [7:0] OFS_HEADER_BYTE_REG0 = 8'h14;
  localparam logic [7:0] OFS_HEADER_BYTE_REG3 = 8'h20;
  // Header registers sit on consecutive words from the first one
  // Control field positions
  localparam int CB_INTERP = 7;
  localparam int CB_DETECT = 6;
  localparam int CB_DESCR = 5;
  localparam int CB_REWRITE = 4;
  localparam int CB_MODE = 3;
  localparam int CB_FORM = 2;
  localparam int CB_MCHK = 1;
  localparam int CB_SHSEL = 0;
  localparam int CA_AUTO = 4;
  localparam int SUBMODE_FORM_BIT = 5;
  // Reset values
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  // Block timing, in 16-bit words after the end of sync
  localparam logic [10:0] WC_SYNC_POS = 11'h497;
  localparam logic [10:0] WC_DATA_END = 11'h492;
  localparam logic [10:0] WC_MAX = 11'h7FF;
  localparam int HDR_WORDS = 6;
  // Sync pattern words and scrambler seed
  localparam logic [15:0] SYNC_FIRST = 16'h00FF;
  localparam logic [15:0] SYNC_MID = 16'hFFFF;
  localparam logic [15:0] SYNC_LAST = 16'hFF00;
  localparam logic [14:0] SCR_SEED = 15'h0001;
  // Expected mode byte values
  localparam logic [7:0] MODE1_BYTE = 8'h01;
  localparam logic [7:0] MODE2_BYTE = 8'h02;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Block timing states
  typedef enum logic [0:0] {BT_RUN = 1'b0, BT_LONG = 1'b1} cdd_bt_t;
endpackage
`default_nettype wire

// ---- cdd_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdd_props
  import cdd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic out_valid,
  input wire logic block_end,
  input wire logic corr_enable,
  input wire logic corr_mode,
  input wire logic corr_form,
  input wire logic rewrite_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stay put until the master takes them
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_HEADER_BYTE_REG3
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_arready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_word_pulse: assert property (out_valid || block_end |=> !out_valid && !block_end)
    else $error("pulse too long");
  // Corrector levels only move at a block boundary
  a_levels_held: assert property (
    $changed({corr_enable, corr_mode, corr_form, rewrite_enable}) |->
    block_end || $past(block_end)) else $error("levels moved mid-block");
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property (block_end);
endmodule
bind cdd_ctrl_status cdd_props #(.ADDR_W(ADDR_W)) props_u (.*);
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb_top;
  import cdd_pkg::*;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic [1:0] r;} cdd_exp_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, min_b, b16, d;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'hB75C;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, erasure_input;
  logic din_toggle, out_valid, block_end, corr_enable, corr_mode, corr_form, rewrite_enable;
  logic [15:0] din_word, out_word;
  logic corr_done = 1'h0, corr_crc_ok = 1'h0, corr_uncorrectable = 1'h0;
  int error_cnt = 0, n_tests = 0, wcnt = 0;
  cdd_exp_t rq[$], bq[$], eq[$], x;
  logic [15:0] oq[$], ow;
  cdd_ctrl_status dut_u (.*);
  cdd_dsp_model dsp_u (.aclk(aclk), .din_toggle(din_toggle), .din_word(din_word),
    .erasure_input(erasure_input));
  always #25 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Each answer meets the oldest expectation of its kind
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      x = rq.pop_front();
      `CHK(s_axi_rdata & x.m, x.v)
      `CHK(s_axi_rresp, x.r)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      x = bq.pop_front();
      `CHK(s_axi_bresp, x.r)
    end
    if (block_end) begin
      x = eq.pop_front();
      `CHK(wcnt & x.m, x.v)
      `CHK({corr_enable, corr_mode}, x.r)
      wcnt = 0;
    end else if (out_valid) wcnt++;
    // Raw words pass through unchanged while descrambling is off
    if (out_valid && oq.size() > 0) begin
      ow = oq.pop_front();
      `CHK(out_word, ow)
    end
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m,
      input logic [1:0] r);
    @(posedge aclk);
    rq.push_back('{{24'h0, v & m}, {24'hFFFFFF, m}, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
    @(posedge aclk);
    bq.push_back('{32'h0, 32'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic corr(input logic ok, input logic unc);
    @(posedge aclk);
    corr_done <= 1'h1;
    corr_crc_ok <= ok;
    corr_uncorrectable <= unc;
    @(posedge aclk);
    corr_done <= 1'h0;
  endtask
  // Random block body; header bytes pinned where the checks need them
  task automatic data(input int n, input logic [1:0] e0, input logic [1:0] e1,
      input logic [1:0] e4, input logic peek);
    logic [15:0] w;
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      w = rnd[15:0];
      if (i == 1) w[7:0] = MODE2_BYTE;
      if (i == 3) w[13] = 1'h1;
      if (i == 0) min_b = w[15:8];
      if (i == 2) b16 = w[15:8];
      if (i < WC_DATA_END) oq.push_back(w);
      if (peek && i == 6) rd(OFS_MFSTAT, 8'hF1, 8'hF3, RESP_OKAY);
      dsp_u.send(w, i == 0 ? e0 : i == 1 ? e1 : i == 4 ? e4 : 2'h0);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog: about twice the expected run
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    for (int a = 0; a < 16; a += 4) rd(a[7:0], 8'h00, 8'hFF, RESP_OKAY);
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      d = (i < 8) ? 8'h01 << i : rnd[7:0];
      wr(OFS_CTRL_B, d, RESP_OKAY);
      rd(OFS_CTRL_B, d, 8'hFF, RESP_OKAY);
    end
    wr(8'h24, 8'hFF, RESP_SLVERR);
    rd(8'h24, 8'h00, 8'hFF, RESP_SLVERR);
    wr(OFS_BSTAT, 8'hFF, RESP_OKAY);
    rd(OFS_BSTAT, 8'h00, 8'hFF, RESP_OKAY);
    // Clean block: first sync aligns, second closes at 1175
    wr(OFS_CTRL_B, 8'hC8, RESP_OKAY);
    eq.push_back('{32'h0, 32'h0, 2'h3});
    dsp_u.sync_pat();
    eq.push_back('{32'h492, 32'hFFFFFFFF, 2'h3});
    data(1170, 2'h2, 2'h0, 2'h2, 1'h0);
    dsp_u.sync_pat();
    corr(1'h1, 1'h1);
    rd(OFS_BSTAT, 8'h83, 8'hFF, RESP_OKAY);
    rd(OFS_HERR, 8'h88, 8'hFF, RESP_OKAY);
    rd(OFS_MFSTAT, 8'h08, 8'h0C, RESP_OKAY);
    rd(OFS_HEADER_BYTE_REG0, min_b, 8'hFF, RESP_OKAY);
    wr(OFS_CTRL_B, 8'hC9, RESP_OKAY);
    rd(OFS_HEADER_BYTE_REG0, b16, 8'hFF, RESP_OKAY);
    // No interpolation and no sync at 1175: stretched block
    wr(OFS_CTRL_B, 8'h48, RESP_OKAY);
    eq.push_back('{32'h492, 32'hFFFFFFFF, 2'h3});
    data(1180, 2'h0, 2'h1, 2'h0, 1'h1);
    dsp_u.sync_pat();
    corr(1'h0, 1'h0);
    rd(OFS_BSTAT, 8'h72, 8'hFF, RESP_OKAY);
    rd(OFS_HERR, 8'h10, 8'hFF, RESP_OKAY);
    rd(OFS_MFSTAT, 8'h0C, 8'h0C, RESP_OKAY);
    repeat (2) @(posedge aclk);
    print_verdict();
  end
endmodule
`default_nettype wire
